// ---- dv/pipelined_sync_sram_port_tb.sv ----
/*
 * Self-checking bench for sync_sram_port: a reference model predicts the
 * line state per edge, and scenarios cover lanes, bursts, freeze and sleep.
 * Assumes the host model resolves the lines and all time passes via issue.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_defines.svh"

module pipelined_sync_sram_port_tb;
	typedef struct {int due; logic drv; logic [35:0] w;} exp_s;
	// Command codes {select, write_n, step}.
	localparam logic [2:0] RD = 3'h6;
	localparam logic [2:0] WR = 3'h4;
	localparam logic [2:0] DS = 3'h2;
	localparam logic [2:0] SP = 3'h3;
	localparam logic [2:0] SW = 3'h1;

	logic                    ref_clk_in = 1'h0;
	logic                    rstn_in    = 1'h0;
	logic [`SRAM_ADDR_W-1:0] addr       = '0;
	logic                    cs1_n      = 1'h1;
	logic                    cs2        = 1'h0;
	logic                    cs3_n      = 1'h1;
	logic                    we_n       = 1'h1;
	logic                    adv        = 1'h0;
	logic                    qual_n     = 1'h0;
	logic                    oe_n       = 1'h0;
	logic                    slp        = 1'h0;
	logic                    strap      = 1'h1;
	logic [3:0]              ben        = 4'hF;
	logic                    go         = 1'h0;
	logic [35:0]             gword      = 36'h0;
	logic [31:0]             dq_out;
	logic [31:0]             dq_oe;
	logic [3:0]              par_out;
	logic [3:0]              par_oe;
	logic                    wr_rdy;
	logic [35:0]             line;
	logic                    hdrv;
	exp_s                    exp_q[$];
	exp_s                    mon_e;
	logic [35:0]             mem[int];
	logic [`SRAM_ADDR_W-1:0] cur;
	logic [1:0]              st;
	logic [1:0]              k;
	int                      acc = 0;
	int                      now = 0;
	int                      fails = 0;
	int                      checks_done = 0;
	logic                    hold = 1'h0;
	logic                    asleep = 1'h0;

	always #5 ref_clk_in = ~ref_clk_in;

	sync_sram_port sync_sram_port_i (
		.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .address_in(addr),
		.chip_select_1_n_in(cs1_n), .chip_select_2_in(cs2), .chip_select_3_n_in(cs3_n),
		.write_enable_n_in(we_n), .byte_lane_write_n_in(ben), .burst_step_or_load_in(adv),
		.clock_qualify_n_in(qual_n), .output_enable_n_in(oe_n), .sleep_request_in(slp),
		.burst_mode_strap_in(strap), .data_in(line[31:0]), .data_out(dq_out),
		.data_oe_out(dq_oe), .parity_lines_in(line[35:32]), .parity_lines_out(par_out),
		.parity_lines_oe_out(par_oe), .write_ready_out(wr_rdy));

	sram_host_model sram_host_model_i (
		.ref_clk_in(ref_clk_in), .clock_qualify_n_in(qual_n), .wr_go_in(go),
		.wr_word_in(gword), .dev_out_in({par_out, dq_out}), .dev_oe_in({par_oe, dq_oe}),
		.line_out(line), .host_drv_out(hdrv));

	task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_drv(input logic [35:0] got, input logic exp);
		chk_word(got, {36{exp}});
	endtask

	// Lane merge of the reference memory, parity bit with its byte.
	function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] n, logic [3:0] b);
		for (int i = 0; i < 4; i++) begin
			if (!b[i]) begin
				o[8*i +: 8] = n[8*i +: 8];
				o[32+i] = n[32+i];
			end
		end
		return o;
	endfunction

	// One edge: present a command and predict the lines two edges on.
	task automatic issue(input logic [2:0] op, input logic [`SRAM_ADDR_W-1:0] a,
			input logic [3:0] b, input logic [35:0] w);
		exp_s e;
		logic g;
		g = 1'h0;
		@(posedge ref_clk_in);
		if (!qual_n) begin
			now++;
		end
		if (!hold && !asleep) begin
			if (!op[0]) begin
				acc = !op[2] ? 0 : (op[1] ? 1 : 2);
				cur = a;
				st = a[1:0];
				k = 2'h0;
			end else if (acc != 0) begin
				k = k + 2'h1;
				cur[1:0] = strap ? (st ^ k) : (st + k);
			end
			if (acc == 2) begin
				mem[cur] = mrg(mem.exists(cur) ? mem[cur] : 'x, w, b);
				g = 1'h1;
			end
			e.due = now + 2;
			e.drv = (acc == 1);
			e.w = e.drv ? mem[cur] : 36'h0;
			exp_q.push_back(e);
		end
		{cs1_n, cs2, cs3_n, we_n, adv, qual_n} <= {!op[2], op[2], !op[2], op[1], op[0], hold};
		{addr, ben, go, gword} <= {a, b, g, w};
	endtask

	task automatic idle(input int n);
		repeat (n) issue(DS, '0, 4'hF, 36'h0);
	endtask

	// Predicted line state, plus no drive while the host owns the lines.
	always @(posedge ref_clk_in) begin
		#1;
		if (exp_q.size() > 0 && exp_q[0].due == now) begin
			mon_e = exp_q.pop_front();
			chk_drv({par_oe, dq_oe}, mon_e.drv && !oe_n);
			if (mon_e.drv && !oe_n) begin
				chk_word(line, mon_e.w);
			end
		end
		if (hdrv) begin
			chk_drv({par_oe, dq_oe}, 1'h0);
		end
	end

	task automatic t_rw();
		issue(WR, 17'h00010, 4'h0, 36'hF12345678);
		issue(WR, 17'h00010, 4'hA, 36'h0ABCDEF01);
		issue(RD, 17'h00010, 4'hF, 36'h0);
		issue(WR, 17'h00011, 4'h5, 36'hA55AA33CC);
		issue(RD, 17'h00010, 4'hF, 36'h0);
		idle(1);
		oe_n <= 1'h1;
		idle(2);
		oe_n <= 1'h0;
		idle(3);
		chk_word({35'h0, wr_rdy}, 36'h1);
		$display("test rw done, fails=%0d", fails);
	endtask

	// Start 1 gives distinct linear and interleaved sequences.
	task automatic t_burst();
		for (int m = 0; m < 2; m++) begin
			strap <= m[0];
			idle(3);
			issue(WR, 17'h00201, 4'h0, {4'h9, 16'hA5C3, m[7:0], 8'h00});
			for (int j = 1; j < 4; j++) begin
				issue(SP, '0, 4'h0, {j[3:0], 16'h5A3C, m[7:0], j[7:0]});
			end
			for (int j = 0; j < 4; j++) begin
				issue(RD, {15'h0080, j[1:0]}, 4'hF, 36'h0);
			end
			issue(RD, 17'h00201, 4'hF, 36'h0);
			repeat (3) issue(SW, '0, 4'hF, 36'h0);
			idle(3);
		end
		issue(SP, '0, 4'hF, 36'h0);
		idle(3);
		$display("test burst done, fails=%0d", fails);
	endtask

	task automatic t_freeze();
		issue(RD, 17'h00010, 4'hF, 36'h0);
		idle(1);
		hold = 1'h1;
		repeat (3) begin
			issue(RD, 17'h00201, 4'hF, 36'h0);
			#1;
			chk_word(line, mem[17'h00010]);
			chk_drv({par_oe, dq_oe}, 1'h1);
		end
		hold = 1'h0;
		idle(3);
		$display("test freeze done, fails=%0d", fails);
	endtask

	task automatic t_sleep();
		idle(2);
		slp <= 1'h1;
		asleep = 1'h1;
		idle(4);
		issue(WR, 17'h00010, 4'h0, 36'h0DEADBEEF);
		idle(3);
		chk_drv({par_oe, dq_oe}, 1'h0);
		slp <= 1'h0;
		idle(4);
		asleep = 1'h0;
		issue(RD, 17'h00010, 4'hF, 36'h0);
		idle(3);
		$display("test sleep done, fails=%0d", fails);
	endtask

	task automatic close_out();
		$display("checks=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge ref_clk_in);
		rstn_in <= 1'h1;
		#1;
		chk_drv({par_oe, dq_oe}, 1'h0);
		t_rw();
		t_burst();
		t_freeze();
		t_sleep();
		close_out();
	end

	// The tests need about 100 cycles; 5000 leaves ample margin.
	initial begin
		#50000;
		fails++;
		close_out();
	end
endmodule // pipelined_sync_sram_port_tb

`default_nettype wire

// ---- dv/sram_host_model.sv ----
/*
 * Host-side data model for the SRAM port: delays write data into the data
 * phase and resolves the shared data and parity lines.
 * Assumes the bench raises wr_go_in just after the edge that issues a write.
 */
`timescale 1ns/100ps
`default_nettype none

module sram_host_model (
	// Clock and qualifier
	input  wire logic        ref_clk_in,
	input  wire logic        clock_qualify_n_in,
	// Write cycles from the bench
	input  wire logic        wr_go_in,
	input  wire logic [35:0] wr_word_in,
	// Device side of the lines
	input  wire logic [35:0] dev_out_in,
	input  wire logic [35:0] dev_oe_in,
	// Resolved lines
	output logic      [35:0] line_out,
	output logic             host_drv_out
);
	logic        go_q   = 1'h0;
	logic        drv_q  = 1'h0;
	logic [35:0] wd_q   = 36'h0;
	logic [35:0] hw_q   = 36'h0;
	logic [35:0] last_q = 36'h0;

	// data two edges on
	// The host drives only across the data-phase edge and then lets go.
	always @(posedge ref_clk_in) begin
		if (!clock_qualify_n_in) begin
			go_q <= wr_go_in;
			wd_q <= wr_word_in;
			drv_q <= go_q;
			hw_q <= wd_q;
		end
		last_q <= line_out;
	end

	assign host_drv_out = drv_q;
	// Released lines toggle each cycle, so a stale word never looks valid.
	assign line_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & (drv_q ? hw_q : ~last_q));
endmodule // sram_host_model

`default_nettype wire

// ---- hw/sram_port_defines.svh ----
/*
 * Constants shared by the pipelined synchronous SRAM port and its package.
 * Assumes inclusion by bare name from files under hw/.
 */
// Operation
// R1 - Sleep input stops timed work, keeps contents
// R2 - Controller holds sleep low; floating means off
// R3 - Data lines captured on rising edge
// R4 - Read returns location addressed at read start
// R5 - Lines drive only with enable low, logic permitting
// R6 - Enable high floats data and parity
// R7 - Float in write data, after deselect, deselected
// R8 - Parity lines follow data, per lane select
// R9 - Strap low linear, high or open interleaved
// R10 - Qualifier high freezes every internal state; code still clocks the sleep and strap synchronizers and lets sleep act
// R11 - Synchronous inputs registered on rising edge
// R12 - Read data leaves through output registers
// R13 - Controller asserts all chip selects to start
// R14 - Load low latches a new start address
// R15 - Write strobe low writes, high reads
// R16 - Write touches only selected byte lanes
// R17 - Writes are internally self-timed
// R18 - Reads, writes, deselects all pipelined
// R19 - Controller loads fresh address after deselect
// R20 - Output enable acts asynchronously on drivers
// R21 - Read data appears at the next edge
// R22 - Step high advances burst, keeps access type
// R23 - Write data latched two edges after command
// R24 - Burst order linear add or interleaved XOR
// R25 - Selected when select one, three low, two high
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define SRAM_ADDR_W     17
`define SRAM_LANES      4
`define SRAM_LANE_W     8
`define SRAM_BURST_W    2
`define SRAM_BUF_DEPTH  2

// ****************************************************************
// Reset values
// ****************************************************************
`define SRAM_STRAP_RST  1'b1
`define SRAM_STEP_RST   2'h0

`endif

// ---- hw/sram_port_pkg.sv ----
/*
 * Types for the pipelined synchronous SRAM port: access states, command and
 * write-entry carriers, and the byte-lane merge used on writes and forwarding.
 * Assumes sram_port_defines.svh sits beside it.
 */
`include "sram_port_defines.svh"

package sram_port_pkg;
	// Each lane slot holds its parity bit above its eight data bits.
	localparam int LANE_SLOT = `SRAM_LANE_W + 1;
	localparam int WORD_W    = `SRAM_LANES * LANE_SLOT;

	typedef logic [WORD_W-1:0] word_t;

	typedef enum logic [3:0] {
		ACC_DESEL = 4'b0001,
		ACC_READ  = 4'b0010,
		ACC_WRITE = 4'b0100,
		ACC_SLEEP = 4'b1000
	} access_e;

	typedef struct packed {
		access_e                  acc;
		logic [`SRAM_ADDR_W-1:0]  addr;
		logic [`SRAM_LANES-1:0]   be;
	} cmd_s;

	typedef struct packed {
		logic [`SRAM_ADDR_W-1:0]  addr;
		logic [`SRAM_LANES-1:0]   be;
		word_t                    word;
	} wr_entry_s;

	// Replaces only the lanes whose enable is set.
	function automatic word_t lane_merge(word_t old_w, word_t new_w,
			logic [`SRAM_LANES-1:0] be);
		word_t r;
		r = old_w;
		for (int i = 0; i < `SRAM_LANES; i++) begin
			if (be[i]) begin
				r[i*LANE_SLOT +: LANE_SLOT] = new_w[i*LANE_SLOT +: LANE_SLOT];
			end
		end
		return r;
	endfunction
endpackage

// ---- hw/sync_sram_port.sv ----
/*
 * Device side of a pipelined synchronous burst SRAM: command pipeline,
 * burst counter, byte-lane writes via a pending-write buffer, registered
 * read data and tri-state control of data and parity lines.
 * Assumes the controller runs on ref_clk_in; output enable, sleep and the
 * burst strap are asynchronous to it. Tri-state wires are resolved outside.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_defines.svh"

module sync_sram_port
	import sram_port_pkg::*;
#(
	parameter int BUF_DEPTH = `SRAM_BUF_DEPTH
) (
	// Clock and reset
	input  wire logic                    ref_clk_in,
	input  wire logic                    rstn_in,
	// Synchronous controls
	input  wire logic [`SRAM_ADDR_W-1:0] address_in,
	input  wire logic                    chip_select_1_n_in,
	input  wire logic                    chip_select_2_in,
	input  wire logic                    chip_select_3_n_in,
	input  wire logic                    write_enable_n_in,
	input  wire logic [`SRAM_LANES-1:0]  byte_lane_write_n_in,
	input  wire logic                    burst_step_or_load_in,
	input  wire logic                    clock_qualify_n_in,
	// Asynchronous controls and strap
	input  wire logic                    output_enable_n_in,
	input  wire logic                    sleep_request_in,
	input  wire logic                    burst_mode_strap_in,
	// Data lines
	input  wire logic [31:0]             data_in,
	output logic      [31:0]             data_out,
	output logic      [31:0]             data_oe_out,
	// Parity lines
	input  wire logic [`SRAM_LANES-1:0]  parity_lines_in,
	output logic      [`SRAM_LANES-1:0]  parity_lines_out,
	output logic      [`SRAM_LANES-1:0]  parity_lines_oe_out,
	// Pending-write buffer status
	output logic                         write_ready_out
);
	localparam int DEPTH_WORDS = 1 << `SRAM_ADDR_W;

	if (`SRAM_LANES * `SRAM_LANE_W != 32 || BUF_DEPTH < 2) begin : g_bad_cfg
		$error("sync_sram_port: needs 32 data bits and BUF_DEPTH of 2 or more");
	end

	// ****************************************************************
	// Storage and state
	// ****************************************************************
	word_t mem [DEPTH_WORDS];

	logic sleep_s1_q, sleep_s1_d, sleep_q, sleep_d;
	logic mode_s1_q, mode_s1_d, interleave_q, interleave_d;
	cmd_s cmd_q, cmd_d;
	cmd_s wr_q, wr_d;
	logic [`SRAM_BURST_W-1:0] start_q, start_d, step_q, step_d;
	logic [`SRAM_BURST_W-1:0] next_step, burst_low;
	word_t out_q, out_d;
	logic  drive_q, drive_d;

	word_t     pin_word, rd_word;
	logic      selected, active, lines_on;
	logic      buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
	wr_entry_s buf_in_data, buf_head;

	// ****************************************************************
	// Asynchronous inputs
	// ****************************************************************

	// Two flops each; sleep thereby takes two cycles to enter and leave.
	always_comb begin
		sleep_s1_d   = sleep_request_in;
		sleep_d      = sleep_s1_q;
		mode_s1_d    = burst_mode_strap_in;
		interleave_d = mode_s1_q;
	end

	// R2 floating sleep off: reset leaves sleep clear, the pull-down is external.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			sleep_s1_q   <= 1'b0;
			sleep_q      <= 1'b0;
			mode_s1_q    <= `SRAM_STRAP_RST;
			interleave_q <= `SRAM_STRAP_RST;
		end else begin
			sleep_s1_q   <= sleep_s1_d;
			sleep_q      <= sleep_d;
			mode_s1_q    <= mode_s1_d;
			interleave_q <= interleave_d;
		end
	end

	// ****************************************************************
	// Command pipeline and burst counter
	// ****************************************************************

	// R25 select decode; R13 the controller must assert all three.
	assign selected = !chip_select_1_n_in & chip_select_2_in & !chip_select_3_n_in;
	// R10 qualifier gate: no synchronous work unless low and awake.
	assign active   = !clock_qualify_n_in & !sleep_q;

	// R24 burst order: the strap chooses XOR or wrapping add.
	always_comb begin
		next_step = step_q + `SRAM_BURST_W'(1);
		burst_low = start_q + next_step;
		// R9 strap order: high or open selects interleaved.
		if (interleave_q) begin
			burst_low = start_q ^ next_step;
		end
	end

	// R11 input registers: controls are sampled only at a qualified edge.
	always_comb begin
		cmd_d   = cmd_q;
		wr_d    = wr_q;
		start_d = start_q;
		step_d  = step_q;
		if (sleep_q) begin
			// R1 sleep entry: command and data phase are dropped, buffered writes and memory are kept.
			cmd_d.acc = ACC_SLEEP;
			wr_d.acc  = ACC_DESEL;
		end else if (active) begin
			// R18 pipelined stages: the command moves on to the data phase.
			wr_d = cmd_q;
			if (cmd_q.acc != ACC_WRITE) begin
				wr_d.acc = ACC_DESEL;
			end
			cmd_d.be = ~byte_lane_write_n_in;
			if (!burst_step_or_load_in) begin
				// R14 address load; R19 after deselect a load is expected.
				cmd_d.addr = address_in;
				start_d    = address_in[`SRAM_BURST_W-1:0];
				step_d     = `SRAM_STEP_RST;
				// R15 access type from the write strobe.
				if (!selected) begin
					cmd_d.acc = ACC_DESEL;
				end else if (write_enable_n_in) begin
					cmd_d.acc = ACC_READ;
				end else begin
					cmd_d.acc = ACC_WRITE;
				end
			end else begin
				// R22 burst step keeps type, except a sleep becomes deselect, and ignores selects and strobe.
				step_d = next_step;
				cmd_d.addr[`SRAM_BURST_W-1:0] = burst_low;
				if (cmd_q.acc == ACC_SLEEP) begin
					cmd_d.acc = ACC_DESEL;
				end
			end
		end
	end

	// Command pipeline registers.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			cmd_q   <= '{acc: ACC_DESEL, addr: '0, be: '0};
			wr_q    <= '{acc: ACC_DESEL, addr: '0, be: '0};
			start_q <= `SRAM_STEP_RST;
			step_q  <= `SRAM_STEP_RST;
		end else begin
			cmd_q   <= cmd_d;
			wr_q    <= wr_d;
			start_q <= start_d;
			step_q  <= step_d;
		end
	end

	// ****************************************************************
	// Write path
	// ****************************************************************

	// R3 data capture: pins pack into lane slots with parity on top.
	always_comb begin
		pin_word = '0;
		for (int i = 0; i < `SRAM_LANES; i++) begin
			pin_word[i*LANE_SLOT +: LANE_SLOT] =
				{parity_lines_in[i], data_in[i*`SRAM_LANE_W +: `SRAM_LANE_W]};
		end
	end

	// R23 data latch: the phase after the command takes the pins at its edge.
	assign buf_in_valid  = active & (wr_q.acc == ACC_WRITE);
	assign buf_in_data   = '{addr: wr_q.addr, be: wr_q.be, word: pin_word};
	// R17 self-timed commit: the array drains whenever the port is live.
	assign buf_out_ready = active;
	assign write_ready_out = buf_in_ready;

	// A stalled drain keeps the word; the buffer absorbs it instead of losing it.
	two_entry_buffer #(
		.W     ($bits(wr_entry_s)),
		.DEPTH (BUF_DEPTH)
	) u_pending (
		.ref_clk_in    (ref_clk_in),
		.rstn_in       (rstn_in),
		.in_valid_in   (buf_in_valid),
		.in_ready_out  (buf_in_ready),
		.in_data_in    (buf_in_data),
		.out_valid_out (buf_out_valid),
		.out_ready_in  (buf_out_ready),
		.out_data_out  (buf_head)
	);

	// R16 byte lanes; R8 parity rides with its lane select.
	always_ff @(posedge ref_clk_in) begin
		if (buf_out_valid && buf_out_ready) begin
			mem[buf_head.addr] <= lane_merge(mem[buf_head.addr], buf_head.word,
				buf_head.be);
		end
	end

	// ****************************************************************
	// Read path and drivers
	// ****************************************************************

	// R4 addressed word: newer writes still in flight are forwarded.
	always_comb begin
		rd_word = mem[cmd_q.addr];
		if (buf_out_valid && buf_head.addr == cmd_q.addr) begin
			rd_word = lane_merge(rd_word, buf_head.word, buf_head.be);
		end
		if (wr_q.acc == ACC_WRITE && wr_q.addr == cmd_q.addr) begin
			rd_word = lane_merge(rd_word, pin_word, wr_q.be);
		end
	end

	// R21 next edge: read data loads the output register one edge on.
	always_comb begin
		out_d   = out_q;
		drive_d = drive_q;
		if (sleep_q) begin
			drive_d = 1'b0;
		end else if (active) begin
			// R7 float: write data phase, deselect and its first cycle out.
			drive_d = (cmd_q.acc == ACC_READ);
			if (cmd_q.acc == ACC_READ) begin
				out_d = rd_word;
			end
		end
	end

	// R12 output register: pins never see the array directly.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			out_q   <= '0;
			drive_q <= 1'b0;
		end else begin
			out_q   <= out_d;
			drive_q <= drive_d;
		end
	end

	// R20 asynchronous enable; R5 needs it low; R6 high floats everything.
	assign lines_on = drive_q & !output_enable_n_in;

	// R8 parity drivers share the data enable.
	always_comb begin
		for (int i = 0; i < `SRAM_LANES; i++) begin
			data_out[i*`SRAM_LANE_W +: `SRAM_LANE_W] =
				out_q[i*LANE_SLOT +: `SRAM_LANE_W];
			parity_lines_out[i] = out_q[i*LANE_SLOT + `SRAM_LANE_W];
		end
		data_oe_out         = {32{lines_on}};
		parity_lines_oe_out = {`SRAM_LANES{lines_on}};
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	logic [`SRAM_BURST_W-1:0] cmd_low;
	assign cmd_low = cmd_q.addr[`SRAM_BURST_W-1:0];

	read_latency_a: // R21
		assert property (active && cmd_q.acc == ACC_READ |=> drive_q)
		else $error("read data not driven one edge after the read");
	oe_float_a: // R6
		assert property (output_enable_n_in |-> data_oe_out == '0)
		else $error("data driven while output enable is high");
	write_float_a: // R7
		assert property (wr_q.acc == ACC_WRITE |-> !drive_q && data_oe_out == '0)
		else $error("lines driven during write data phase");
	desel_float_a: // R7
		assert property (active && cmd_q.acc == ACC_DESEL |=> data_oe_out == '0)
		else $error("lines driven after a deselect");
	qual_hold_a: // R10
		assert property (clock_qualify_n_in && !sleep_q |=>
			$stable(cmd_q) && $stable(out_q) && $stable(step_q))
		else $error("state changed while the qualifier was high");
	addr_load_a: // R14
		assert property (active && !burst_step_or_load_in && selected |=>
			cmd_q.addr == $past(address_in))
		else $error("start address not latched");
	access_type_a: // R15
		assert property (active && !burst_step_or_load_in && selected |=>
			cmd_q.acc == ($past(write_enable_n_in) ? ACC_READ : ACC_WRITE))
		else $error("access type does not follow the write strobe");
	linear_step_a: // R24
		assert property (active && burst_step_or_load_in && !interleave_q |=>
			cmd_low == 2'($past(cmd_low) + 2'h1) && $stable(cmd_q.acc))
		else $error("linear burst step wrong");
	parity_follow_a: // R8
		assert property (parity_lines_oe_out == {`SRAM_LANES{data_oe_out[0]}})
		else $error("parity enable differs from data enable");
	sleep_quiet_a: // R1
		assert property (sleep_q |=> data_oe_out == '0 && !buf_in_valid)
		else $error("activity while asleep");
	write_latch_a: // R23
		assert property (active && cmd_q.acc == ACC_WRITE ##1 active |->
			buf_in_valid && buf_in_data.word == pin_word &&
			buf_in_data.addr == $past(cmd_q.addr) && buf_in_data.be == $past(cmd_q.be))
		else $error("write data not taken two edges after command");

	cover_read_c:  cover property (active && cmd_q.acc == ACC_READ ##1 lines_on);
	cover_write_c: cover property (buf_in_valid ##1 buf_out_valid);
	cover_burst_c: cover property (active && burst_step_or_load_in &&
		cmd_q.acc == ACC_READ [*3]);
	cover_sleep_c: cover property (sleep_q ##1 !sleep_q);
endmodule // sync_sram_port

`default_nettype wire

// ---- hw/two_entry_buffer.sv ----
/*
 * Small valid/ready FIFO, default two entries, used for pending writes.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         ref_clk_in,
	input  wire logic         rstn_in,
	// Fill side
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	// Drain side
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Pointers wrap naturally, so only powers of two are served.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("two_entry_buffer: DEPTH must be a power of two, at least 2");
	end

	logic [W-1:0] slot_q [DEPTH];
	logic [PW-1:0] rptr_q, rptr_d;
	logic [PW-1:0] wptr_q, wptr_d;
	logic [PW:0]   cnt_q, cnt_d;
	logic          push, pop;

	// Handshakes are combinational; full and empty come from the count.
	assign in_ready_out  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out  = slot_q[rptr_q];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	// Pointer and occupancy next values.
	always_comb begin
		wptr_d = wptr_q + PW'(push);
		rptr_d = rptr_q + PW'(pop);
		cnt_d  = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
	end

	// Pointer registers.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q  <= cnt_d;
		end
	end

	// Storage needs no reset; the count says what is valid.
	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			slot_q[wptr_q] <= in_data_in;
		end
	end
endmodule // two_entry_buffer

`default_nettype wire
